// ==== hdl/eeb_pkg.sv ====
// Purpose: Shared constants and types of the data EEPROM byte controller
// Assumes: 40 MHz clock, APB register access with 32-bit words
// Notes:   All offsets are byte addresses of aligned words
package eeb_pkg;
   localparam int unsigned NV_BYTES = 512;
   localparam int unsigned ADDR_W   = 9;
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned TICK_W   = 12;
   localparam int unsigned STAT_W   = 3;

   localparam logic [7:0] OFF_ADDR = 8'h00;
   localparam logic [7:0] OFF_DATA = 8'h04;
   localparam logic [7:0] OFF_CTRL = 8'h08;
   localparam logic [7:0] OFF_STAT = 8'h0C;
   localparam logic [7:0] OFF_MASK = 8'h10;

   localparam int unsigned CTRL_RD_BIT    = 0;
   localparam int unsigned CTRL_START_BIT = 1;
   localparam int unsigned CTRL_MWE_BIT   = 2;
   localparam int unsigned CTRL_MODE_LSB  = 4;

   localparam int unsigned ST_RDDONE = 0;
   localparam int unsigned ST_PGDONE = 1;
   localparam int unsigned ST_REFUSE = 2;

   localparam logic [8:0] ADDR_RST = 9'h000;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [2:0] STAT_RST = 3'h0;
   localparam logic [2:0] MASK_RST = 3'h0;
   localparam logic [7:0] ERASED   = 8'hFF;

   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned OSC_TICK_NS   = 1000;
   localparam int unsigned TICK_CYC      =
      (OSC_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [2:0] READ_HALT_CYC = 3'h4;
   localparam logic [2:0] PROG_HALT_CYC = 3'h2;
   localparam logic [2:0] ARM_CYC       = 3'h4;

   typedef enum logic [1:0] {
      MODE_ATOMIC = 2'b00,
      MODE_ERASE  = 2'b01,
      MODE_WRITE  = 2'b10,
      MODE_RSVD   = 2'b11
   } eeb_mode_t;

   typedef enum logic [0:0] {
      OP_IDLE = 1'b0,
      OP_BUSY = 1'b1
   } eeb_op_t;
endpackage

// ==== hdl/eeb_nv_if.sv ====
// Purpose: Port bundle between controller and nonvolatile byte array
// Assumes: One access per cycle, read data one cycle after rdEn
// Notes:   erEn and wrEn together form the combined erase and write
`timescale 1ns/1ps
interface eeb_nv_if;
   logic [8:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       rdEn;
   logic       erEn;
   logic       wrEn;
   modport ctrl (output addr, output wdata, output rdEn, output erEn,
                 output wrEn, input rdata);
   modport mem  (input addr, input wdata, input rdEn, input erEn,
                 input wrEn, output rdata);
endinterface

// ==== hdl/eeb_nv_array.sv ====
// Purpose: Byte array standing in for the nonvolatile cells
// Assumes: Contents survive srst; only the read register is reset
// Notes:   A write without erase can only clear bits
`timescale 1ns/1ps
module eeb_nv_array (
   input wire logic clk,
   input wire logic srst,
   eeb_nv_if.mem    nv
);
   typedef struct packed {
      logic [7:0] rdata;
   } eeb_arr_st_t;

   logic [7:0]  cells [eeb_pkg::NV_BYTES];
   eeb_arr_st_t s_r;
   eeb_arr_st_t s_nxt;

   always_comb begin
      s_nxt = s_r;
      if (nv.rdEn) begin
         s_nxt.rdata = cells[nv.addr];
      end
      if (srst) begin
         s_nxt.rdata = eeb_pkg::DATA_RST;
      end
   end

   always_ff @(posedge clk) begin
      s_r <= s_nxt;
   end

   // Erase leaves all ones; a bare write ANDs into whatever is there
   always_ff @(posedge clk) begin
      if (nv.erEn && nv.wrEn) begin
         cells[nv.addr] <= nv.wdata;
      end else if (nv.erEn) begin
         cells[nv.addr] <= eeb_pkg::ERASED;
      end else if (nv.wrEn) begin
         cells[nv.addr] <= cells[nv.addr] & nv.wdata;
      end
   end

   assign nv.rdata = s_r.rdata;
endmodule

// ==== hdl/eeb_prog_timer.sv ====
// Purpose: Self-timed programming interval in 1 us oscillator ticks
// Assumes: start is a one-cycle pulse, ignored while busy
// Notes:   srst does not stop a running interval
`timescale 1ns/1ps
module eeb_prog_timer (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        start,
   input  wire logic [11:0] load,
   output logic             busy,
   output logic             done
);
   typedef struct packed {
      logic [5:0]  div;
      logic [11:0] left;
      logic        busy;
      logic        done;
   } eeb_tmr_st_t;

   eeb_tmr_st_t s_r;
   eeb_tmr_st_t s_nxt;
   logic        tick;
   logic        idle;

   always_comb begin
      s_nxt      = s_r;
      s_nxt.done = 1'b0;
      tick       = (s_r.div == 6'(eeb_pkg::TICK_CYC - 1));
      if (s_r.busy) begin
         s_nxt.div = tick ? 6'h00 : s_r.div + 6'h01;
         if (tick) begin
            if (s_r.left <= 12'h001) begin
               s_nxt.busy = 1'b0;
               s_nxt.done = 1'b1;
            end else begin
               s_nxt.left = s_r.left - 12'h001;
            end
         end
      end else if (start) begin
         s_nxt.busy = 1'b1;
         s_nxt.div  = 6'h00;
         s_nxt.left = load;
      end
      // A reset in the middle of programming lets the cell finish; an
      // unknown power-up state is taken as idle so reset can clear it
      case (s_r.busy)
         1'b1:    idle = 1'b0;
         default: idle = 1'b1;
      endcase
      if (srst && idle) begin
         s_nxt = '0;
      end
   end

   always_ff @(posedge clk) begin
      s_r <= s_nxt;
   end

   assign busy = s_r.busy;
   assign done = s_r.done;
endmodule

// ==== hdl/eeb_eeprom_ctrl.sv ====
// Purpose: Data EEPROM byte read, erase and write controller on APB
// Assumes: APB master is the processor; cpuHalt and pready stall it
// Notes:   Programming times are in microseconds of the tick oscillator
`timescale 1ns/1ps
module eeb_eeprom_ctrl #(
   parameter int unsigned ERASE_US  = 1800,
   parameter int unsigned WRITE_US  = 1800,
   parameter int unsigned ATOMIC_US = 3600
) (
   input  wire logic        clk,
   input  wire logic        srst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   output logic             irq,
   output logic             cpuHalt
);
   typedef struct packed {
      logic [8:0]        addr;
      logic [7:0]        data;
      eeb_pkg::eeb_mode_t mode;
      logic              mwe;
      logic [2:0]        armCnt;
      logic [2:0]        halt;
      eeb_pkg::eeb_op_t  op;
      eeb_pkg::eeb_mode_t opMode;
      logic [8:0]        opAddr;
      logic [7:0]        opData;
      logic              rdPend;
      logic [2:0]        stat;
      logic [2:0]        mask;
      logic [31:0]       rdata;
      logic              err;
   } eeb_ctl_st_t;

   eeb_ctl_st_t s_r;
   eeb_ctl_st_t s_nxt;

   eeb_nv_if nv ();

   logic        acc;
   logic        wrAcc;
   logic        mapped;
   logic        busy;
   logic        tmrBusy;
   logic        tmrDone;
   logic        tmrStart;
   logic [11:0] tmrLoad;
   logic        rdGo;
   logic        wrStrobe;
   logic        startReq;
   logic [2:0]  statSet;
   logic [2:0]  statClr;
   logic [31:0] rdMux;
   logic [31:0] ctrlWord;
   logic        selAddr;
   logic        selData;
   logic        selCtrl;
   logic        selStat;
   logic        selMask;
   logic        wrAddr;
   logic        wrData;
   logic        wrCtrl;
   logic        wrStat;
   logic        wrMask;
   logic        rdReq;
   logic        rdRefused;
   logic        startRefused;
   logic [2:0]  statNxt;

   eeb_prog_timer u_timer (
      .clk   (clk),
      .srst  (srst),
      .start (tmrStart),
      .load  (tmrLoad),
      .busy  (tmrBusy),
      .done  (tmrDone)
   );

   eeb_nv_array u_array (
      .clk  (clk),
      .srst (srst),
      .nv   (nv.mem)
   );

   // Register map, one aligned word each:
   //   ADDR  byte address of the next access
   //   DATA  byte to program, or byte returned by a read
   //   CTRL  read strobe, start and busy, write enable, mode
   //   STAT  read done, programming done, refused; write one to clear
   //   MASK  same layout as STAT, gates the interrupt
   always_comb begin
      selAddr = (paddr == eeb_pkg::OFF_ADDR);
      selData = (paddr == eeb_pkg::OFF_DATA);
      selCtrl = (paddr == eeb_pkg::OFF_CTRL);
      selStat = (paddr == eeb_pkg::OFF_STAT);
      selMask = (paddr == eeb_pkg::OFF_MASK);
      mapped  = selAddr || selData || selCtrl || selStat || selMask;
   end

   // One write select per register keeps the update code flat
   always_comb begin
      wrAddr = wrAcc && selAddr;
      wrData = wrAcc && selData;
      wrCtrl = wrAcc && selCtrl;
      wrStat = wrAcc && selStat;
      wrMask = wrAcc && selMask;
   end

   // The stall also holds off the next register access
   assign pready  = psel && penable && (s_r.halt == 3'h0);
   assign acc     = psel && penable && pready;
   assign wrAcc   = acc && pwrite && mapped;
   assign busy    = (s_r.op == eeb_pkg::OP_BUSY);
   assign prdata  = s_r.rdata;
   assign pslverr = psel && penable && s_r.err;
   assign irq     = |(s_r.stat & s_r.mask);
   assign cpuHalt = (s_r.halt != 3'h0);

   always_comb begin
      ctrlWord = 32'h0000_0000;
      ctrlWord[eeb_pkg::CTRL_START_BIT] = busy;
      ctrlWord[eeb_pkg::CTRL_MWE_BIT]   = s_r.mwe;
      ctrlWord[eeb_pkg::CTRL_MODE_LSB +: 2] = s_r.mode;
   end

   // Read word for the current address; registered ahead of pready
   always_comb begin
      case (paddr)
         eeb_pkg::OFF_ADDR: rdMux = {23'h000000, s_r.addr};
         eeb_pkg::OFF_DATA: rdMux = {24'h000000, s_r.data};
         eeb_pkg::OFF_CTRL: rdMux = ctrlWord;
         eeb_pkg::OFF_STAT: rdMux = {29'h00000000, s_r.stat};
         eeb_pkg::OFF_MASK: rdMux = {29'h00000000, s_r.mask};
         default:           rdMux = 32'h0000_0000;
      endcase
   end

   // Control register strobes
   always_comb begin
      wrStrobe = wrCtrl;
      startReq = wrStrobe && pwdata[eeb_pkg::CTRL_START_BIT];
      rdReq    = wrStrobe && pwdata[eeb_pkg::CTRL_RD_BIT];
      // Reads during a running programming cycle are refused, not queued
      rdGo      = rdReq && !busy && !s_r.rdPend;
      rdRefused = rdReq && busy;
      // Start only counts while the arm window is open; arming and
      // starting in one write would defeat the two-step guard
      tmrStart = startReq && s_r.mwe && !busy &&
                 !pwdata[eeb_pkg::CTRL_MWE_BIT] &&
                 (s_r.mode != eeb_pkg::MODE_RSVD);
      startRefused = startReq && !tmrStart;
      case (s_r.mode)
         eeb_pkg::MODE_ERASE: tmrLoad = 12'(ERASE_US);
         eeb_pkg::MODE_WRITE: tmrLoad = 12'(WRITE_US);
         default:             tmrLoad = 12'(ATOMIC_US);
      endcase
   end

   // Array port: reads on strobe, cell update at end of interval
   always_comb begin
      nv.rdEn  = rdGo;
      nv.addr  = tmrDone ? s_r.opAddr : s_r.addr;
      nv.wdata = s_r.opData;
      nv.erEn  = 1'b0;
      nv.wrEn  = 1'b0;
      if (tmrDone) begin
         case (s_r.opMode)
            eeb_pkg::MODE_ATOMIC: begin
               nv.erEn = 1'b1;
               nv.wrEn = 1'b1;
            end
            eeb_pkg::MODE_ERASE: begin
               nv.erEn = 1'b1;
            end
            eeb_pkg::MODE_WRITE: begin
               nv.wrEn = 1'b1;
            end
            default: begin
               nv.erEn = 1'b0;
            end
         endcase
      end
   end

   // Event flags and software clears
   always_comb begin
      statSet = 3'h0;
      statSet[eeb_pkg::ST_RDDONE] = s_r.rdPend;
      statSet[eeb_pkg::ST_PGDONE] = tmrDone;
      // A refused read or start still leaves a trace
      statSet[eeb_pkg::ST_REFUSE] = rdRefused || startRefused;
      statClr = 3'h0;
      if (wrStat) begin
         statClr = pwdata[2:0];
      end
   end

   // Each flag is sticky; an event in its clearing cycle wins
   for (genvar i = 0; i < eeb_pkg::STAT_W; i++) begin : g_stat
      assign statNxt[i] = statSet[i] || (s_r.stat[i] && !statClr[i]);
   end

   always_comb begin
      s_nxt       = s_r;
      s_nxt.rdata = psel ? rdMux : s_r.rdata;
      s_nxt.err   = psel && !mapped;

      if (s_r.halt != 3'h0) begin
         s_nxt.halt = s_r.halt - 3'h1;
      end

      // Arm window counts down whether or not software uses it
      if (s_r.mwe) begin
         if (s_r.armCnt <= 3'h1) begin
            s_nxt.mwe    = 1'b0;
            s_nxt.armCnt = 3'h0;
         end else begin
            s_nxt.armCnt = s_r.armCnt - 3'h1;
         end
      end

      if (wrAddr) begin
         s_nxt.addr = pwdata[8:0];
      end
      if (wrData) begin
         s_nxt.data = pwdata[7:0];
      end
      if (wrMask) begin
         s_nxt.mask = pwdata[2:0];
      end

      if (wrStrobe) begin
         s_nxt.mode = eeb_pkg::eeb_mode_t'(
            pwdata[eeb_pkg::CTRL_MODE_LSB +: 2]);
         if (pwdata[eeb_pkg::CTRL_MWE_BIT] && !busy) begin
            s_nxt.mwe    = 1'b1;
            s_nxt.armCnt = eeb_pkg::ARM_CYC;
         end
      end

      if (rdGo) begin
         s_nxt.halt   = eeb_pkg::READ_HALT_CYC;
         s_nxt.rdPend = 1'b1;
      end
      if (s_r.rdPend) begin
         s_nxt.data   = nv.rdata;
         s_nxt.rdPend = 1'b0;
      end

      if (tmrStart) begin
         s_nxt.op     = eeb_pkg::OP_BUSY;
         s_nxt.opMode = s_r.mode;
         s_nxt.opAddr = s_r.addr;
         s_nxt.opData = s_r.data;
         s_nxt.mwe    = 1'b0;
         s_nxt.armCnt = 3'h0;
         s_nxt.halt   = eeb_pkg::PROG_HALT_CYC;
      end
      if (tmrDone) begin
         s_nxt.op = eeb_pkg::OP_IDLE;
      end

      s_nxt.stat = statNxt;

      // Registers return to reset values but a running cell update,
      // with the byte and mode it latched, carries on to its end
      if (srst) begin
         s_nxt.addr   = eeb_pkg::ADDR_RST;
         s_nxt.data   = eeb_pkg::DATA_RST;
         s_nxt.mode   = eeb_pkg::MODE_ATOMIC;
         s_nxt.mwe    = 1'b0;
         s_nxt.armCnt = 3'h0;
         s_nxt.halt   = 3'h0;
         s_nxt.rdPend = 1'b0;
         s_nxt.stat   = eeb_pkg::STAT_RST;
         s_nxt.mask   = eeb_pkg::MASK_RST;
         s_nxt.rdata  = 32'h0000_0000;
         s_nxt.err    = 1'b0;
         if (!tmrBusy) begin
            s_nxt.op     = eeb_pkg::OP_IDLE;
            s_nxt.opMode = eeb_pkg::MODE_ATOMIC;
            s_nxt.opAddr = eeb_pkg::ADDR_RST;
            s_nxt.opData = eeb_pkg::DATA_RST;
         end
      end
   end

   always_ff @(posedge clk) begin
      s_r <= s_nxt;
   end
endmodule

// ==== sim/eeb_ctrl_sva.sv ====
// Purpose: Port checks of the EEPROM byte controller
// Assumes: A transfer completes at psel, penable and pready high
// Notes:   A refused command must raise no processor stall
`timescale 1ns/1ps
module eeb_ctrl_sva #(
   parameter int unsigned ERASE_US  = 1800,
   parameter int unsigned WRITE_US  = 1800,
   parameter int unsigned ATOMIC_US = 3600
) (
   input wire logic        clk,
   input wire logic        srst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        irq,
   input wire logic        cpuHalt
);
   logic       take;
   logic       ctlWr;
   logic [2:0] armAge_r;
   logic [2:0] haltCnt_r;
   assign take  = psel && penable && pready;
   assign ctlWr = take && pwrite && paddr == 8'h08;
   // Age counts edges since the last arming write, saturating at 7
   always_ff @(posedge clk) begin
      if (srst) begin
         armAge_r  <= 3'h7;
         haltCnt_r <= 3'h0;
      end else begin
         if (ctlWr && pwdata[2]) begin
            armAge_r <= 3'h1;
         end else if (armAge_r != 3'h7) begin
            armAge_r <= armAge_r + 3'h1;
         end
         haltCnt_r <= cpuHalt ? haltCnt_r + 3'h1 : 3'h0;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   property p_rd_halt;
      ctlWr && pwdata[1:0] == 2'b01 |=>
         (cpuHalt [*4] ##1 !cpuHalt) or !cpuHalt;
   endproperty
   a_rd_halt: assert property (p_rd_halt)
      else $error("read stall length wrong");
   property p_pg_halt;
      ctlWr && pwdata[2:0] == 3'h2 && armAge_r <= 3'h3 &&
         pwdata[5:4] != 2'b11 |=> (cpuHalt [*2] ##1 !cpuHalt) or !cpuHalt;
   endproperty
   a_pg_halt: assert property (p_pg_halt)
      else $error("programming stall length wrong");
   property p_late;
      ctlWr && pwdata[1] && (armAge_r > 3'h4 || pwdata[2] ||
         pwdata[5:4] == 2'b11) |=> !cpuHalt;
   endproperty
   a_late: assert property (p_late)
      else $error("unarmed start was accepted");
   property p_stall;
      psel && penable && cpuHalt |-> !pready;
   endproperty
   a_stall: assert property (p_stall)
      else $error("access completed during stall");
   property p_ready;
      psel && penable && !cpuHalt |-> pready;
   endproperty
   a_ready: assert property (p_ready)
      else $error("access held without stall");
   property p_unmap;
      take && !pwrite && paddr > 8'h10 |-> pslverr && prdata == 32'h0;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped read not flagged");
   property p_mapped;
      take && paddr[1:0] == 2'b00 && paddr <= 8'h10 |-> !pslverr;
   endproperty
   a_mapped: assert property (p_mapped)
      else $error("mapped access flagged");
   property p_halt_max;
      haltCnt_r <= 3'h4;
   endproperty
   a_halt_max: assert property (p_halt_max)
      else $error("stall longer than four cycles");
   property p_irq;
      irq && !(take && pwrite && paddr inside {8'h0C, 8'h10}) |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt dropped without clear");
   c_read: cover property (ctlWr && pwdata[1:0] == 2'b01);
   c_prog: cover property ($rose(cpuHalt) ##2 !cpuHalt);
   c_irq: cover property ($rose(irq));
endmodule
bind eeb_eeprom_ctrl eeb_ctrl_sva #(
   .ERASE_US(ERASE_US), .WRITE_US(WRITE_US), .ATOMIC_US(ATOMIC_US)
) u_sva (
   .clk(clk), .srst(srst), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .irq(irq), .cpuHalt(cpuHalt)
);

// ==== sim/eeb_cpu_model.sv ====
// Purpose: Processor side issuing APB register accesses
// Assumes: Answer sampled at the rising edge that completes the access
// Notes:   Write data is inverted on reads so stale values never match
`timescale 1ns/1ps
module eeb_cpu_model (
   input  wire logic        clk,
   input  wire logic        pready,
   input  wire logic        pslverr,
   input  wire logic [31:0] prdata,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [7:0]       paddr,
   output logic [31:0]      pwdata,
   output logic             hung
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      hung = 1'b0;
   end
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      int n;
      n = 0;
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= w ? d : ~pwdata;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 60);
      if (n >= 60) hung = 1'b1;
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule

// ==== sim/eeprom_byte_access_controller_bench.sv ====
// Purpose: Register level test of the EEPROM byte controller
// Assumes: Programming times shortened to one or two microseconds
// Notes:   Array contents are unknown until programmed
`timescale 1ns/1ps
module eeprom_byte_access_controller_bench;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        psel, penable, pwrite, pready, pslverr, irq, cpuHalt;
   logic        hung, e;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   int          err_total = 0;
   int          checks_done = 0;
   always #12.5 clk = ~clk;
   eeb_eeprom_ctrl #(.ERASE_US(1), .WRITE_US(1), .ATOMIC_US(2)) DUT (
      .clk(clk), .srst(srst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .irq(irq), .cpuHalt(cpuHalt));
   eeb_cpu_model cpu (.clk(clk), .pready(pready), .pslverr(pslverr),
      .prdata(prdata), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .hung(hung));
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   always @(posedge hung) begin
      err_total++;
      tally_and_finish();
   end
   task automatic check(input string nm, input logic [31:0] s,
      input logic [31:0] x);
      checks_done++;
      if (s !== x) begin
         err_total++;
         $display("Error %s expected %h seen %h", nm, x, s);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      cpu.xfer(1'b1, a, d, q, e);
   endtask
   task automatic rdc(input string nm, input logic [7:0] a,
      input logic [31:0] x);
      cpu.xfer(1'b0, a, 32'h0, q, e);
      check(nm, q, x);
   endtask
   // Arm, then start inside the window; mode rides on both writes
   task automatic prog(input logic [1:0] m, input logic [8:0] a,
      input logic [7:0] d);
      wr(8'h00, {23'h0, a});
      wr(8'h04, {24'h0, d});
      wr(8'h08, {26'h0, m, 4'h4});
      wr(8'h08, {26'h0, m, 4'h2});
      @(negedge clk);
      check("start stall", {31'h0, cpuHalt}, 32'h1);
   endtask
   task automatic rb(input logic [8:0] a, input logic [7:0] x);
      wr(8'h00, {23'h0, a});
      wr(8'h08, 32'h1);
      @(negedge clk);
      check("read stall", {31'h0, cpuHalt}, 32'h1);
      rdc("stored byte", 8'h04, {24'h0, x});
   endtask
   task automatic wait_idle();
      int n;
      n = 0;
      do begin
         cpu.xfer(1'b0, 8'h08, 32'h0, q, e);
         n++;
      end while (q[1] !== 1'b0 && n < 100);
      if (n >= 100) begin
         err_total++;
         tally_and_finish();
      end
   endtask
   task automatic ck_irq(input logic x);
      @(negedge clk);
      check("irq", {31'h0, irq}, {31'h0, x});
   endtask
   initial begin
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      for (int i = 0; i < 5; i++) rdc("reset value", 8'(i * 4), 32'h0);
      cpu.xfer(1'b0, 8'h14, 32'h0, q, e);
      check("unmapped data", q, 32'h0);
      check("unmapped error", {31'h0, e}, 32'h1);
      prog(2'b00, 9'h1A5, 8'h3C);
      cpu.xfer(1'b0, 8'h08, 32'h0, q, e);
      check("busy", {31'h0, q[1]}, 32'h1);
      wr(8'h08, 32'h1);
      wait_idle();
      rdc("status", 8'h0C, 32'h6);
      wr(8'h0C, 32'h7);
      rb(9'h1A5, 8'h3C);
      rdc("read done", 8'h0C, 32'h1);
      prog(2'b01, 9'h1A5, 8'h00);
      wait_idle();
      rb(9'h1A5, 8'hFF);
      prog(2'b10, 9'h1A5, 8'h5A);
      wait_idle();
      rb(9'h1A5, 8'h5A);
      wr(8'h0C, 32'h7);
      wr(8'h04, 32'h0);
      wr(8'h08, 32'h4);
      repeat (6) @(posedge clk);
      wr(8'h08, 32'h2);
      wr(8'h08, 32'h4);
      wr(8'h08, 32'h6);
      wr(8'h08, 32'h34);
      wr(8'h08, 32'h32);
      rdc("refused", 8'h0C, 32'h4);
      rb(9'h1A5, 8'h5A);
      wr(8'h0C, 32'h7);
      wr(8'h10, 32'h2);
      ck_irq(1'b0);
      prog(2'b00, 9'h000, 8'h81);
      wait_idle();
      ck_irq(1'b1);
      wr(8'h10, 32'h0);
      ck_irq(1'b0);
      wr(8'h10, 32'h2);
      ck_irq(1'b1);
      wr(8'h0C, 32'h2);
      ck_irq(1'b0);
      // Reset lands in mid-interval; the cell update must still happen
      prog(2'b00, 9'h0F0, 8'hC3);
      @(posedge clk);
      srst <= 1'b1;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      wait_idle();
      rb(9'h0F0, 8'hC3);
      rb(9'h000, 8'h81);
      tally_and_finish();
   end
endmodule
